// File: core/rcf_filter.sv
// Purpose: Accept or drop decision for one classified received frame.
// Assumes: Frame flags are stable while done is high.
// Notes:   Purely combinational; the register bank registers the result.

`timescale 1ns/1ps

module rcf_filter (
	// Software controls.
	input  wire rcf_pkg::rcf_ctrl_t  i_ctrl,
	input  wire logic                i_udp_check_en,
	// Frame under decision.
	input  wire rcf_pkg::rcf_frame_t i_frame,
	input  wire logic [47:0]         i_station_addr,
	// Decision.
	output logic                     o_drop
);

	logic frag_pass;   // Fragment override of UDP checks.
	logic udp_drop;    // Plain UDP checksum failure.
	logic zero_drop;   // Zero UDP checksum refused.
	logic lite_drop;   // UDP-Lite checksum failure.
	logic icmp_drop;   // ICMP checksum failure.
	logic sa_drop;     // Own source address seen.

	// Each cause is computed apart so that one cause never masks another.
	always_comb begin
		// A fragment cannot be checked, so software may let it pass.
		frag_pass = i_ctrl.frag_pass & i_frame.is_udp & i_frame.is_fragment;
		// With the override clear, fragments meet the ordinary checks below.
		// A zero checksum means none was sent, so it is judged apart.
		udp_drop  = i_udp_check_en & i_frame.is_udp & ~i_frame.is_udp_lite & ~i_frame.udp_csum_zero
		          & i_frame.udp_csum_bad & ~frag_pass;
		zero_drop = i_frame.is_udp & i_frame.udp_csum_zero & ~i_ctrl.zero_accept;
		// With UDP-Lite checks off the frame simply passes.
		lite_drop = i_ctrl.udplite_en & i_frame.is_udp_lite & i_frame.udplite_csum_bad & ~frag_pass;
		icmp_drop = i_ctrl.icmp_en & i_frame.is_icmp & ~i_frame.is_fragment & i_frame.icmp_csum_bad;
		sa_drop   = i_ctrl.sa_drop & (i_frame.src_addr == i_station_addr);
		o_drop    = udp_drop | zero_drop | lite_drop | icmp_drop | sa_drop;
	end

endmodule

// File: core/rcf_regs.sv
// Purpose: Receive control two, transmit free space and header status registers.
// Assumes: Plain strobe bus, read data one cycle after the read strobe.
// Notes:   All state is one packed struct registered on every edge.
//
// Notes on behaviour
// - Fragment-pass bit passes fragmented UDP checksum.
// - Pass bit clear: checks ignore fragment status.
// - Zero UDP checksum: accept if bit set.
// - UDP-Lite enable: check receive, generate transmit.
// - UDP-Lite disabled: pass check, no insertion.
// - ICMP enable drops bad unfragmented ICMP frames.
// - Source address filter drops own-address frames.
// - Report free transmit bytes in bits 12..0.
// - Header status presented once per counted frame.
// - Frame valid only with a complete pending frame.
// - Flag ICMP checksum error of current frame.
// - Flag IP header checksum error of current frame.
// - Address pair after free space is reserved.
// - UDP check enable drops bad UDP frames.
//
// The address-and-strobe port was decided locally.

`timescale 1ns/1ps

module rcf_regs (
	// Clock and reset.
	input  wire logic                      i_clk,
	input  wire logic                      i_reset,
	// Register bus.
	input  wire logic [rcf_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [rcf_pkg::DATA_W-1:0] i_wdata,
	input  wire logic                      i_wr,
	input  wire logic                      i_rd,
	output logic [rcf_pkg::DATA_W-1:0]     o_rdata,
	// Receive path.
	input  wire rcf_pkg::rcf_frame_t       i_frame,
	input  wire logic [47:0]               i_station_addr,
	output logic                           o_rx_accept,
	output logic                           o_rx_drop,
	output logic [rcf_pkg::CNT_W-1:0]      o_frame_count,
	// Transmit path.
	input  wire logic [rcf_pkg::TX_FREE_W-1:0] i_tx_free_bytes,
	input  wire logic                      i_tx_is_udp_lite,
	output logic                           o_tx_udplite_csum_gen,
	// Controls to the checksum engines.
	output rcf_pkg::rcf_ctrl_t             o_ctrl,
	output logic                           o_udp_check_en,
	// Interrupt.
	output logic                           o_irq
);

	// Whole state of the bank.
	typedef struct packed {
		rcf_pkg::rcf_ctrl_t                    ctrl;
		logic                                  udp_check_en;
		logic [rcf_pkg::IRQ_W-1:0]             irq_status;
		logic [rcf_pkg::IRQ_W-1:0]             irq_mask;
		rcf_pkg::rcf_hdr_t [rcf_pkg::HDR_DEPTH-1:0] hdr_mem;
		logic [rcf_pkg::PTR_W-1:0]             wr_ptr;
		logic [rcf_pkg::PTR_W-1:0]             rd_ptr;
		logic [rcf_pkg::CNT_W-1:0]             count;
		logic [rcf_pkg::TX_FREE_W-1:0]         tx_free;
		logic [rcf_pkg::DATA_W-1:0]            rdata;
		logic                                  accept;
		logic                                  drop;
		logic                                  tx_gen;
	} rcf_state_t;

	rcf_state_t state;        // Registered state.
	rcf_state_t next_state;   // Value for the next edge.

	logic                          filt_drop;   // Filter decision for the current frame.
	logic                          push;        // Accepted frame enters the store.
	logic                          pop;         // Host consumed one header status.
	logic                          overflow;    // Accepted frame found the store full.
	logic                          pending;     // At least one frame is waiting.
	logic [rcf_pkg::IRQ_W-1:0]     events;      // Events of this cycle.
	rcf_pkg::rcf_hdr_t             head;        // Oldest pending header status.

	// The frame decision is kept apart so the bank stays readable.
	rcf_filter u_filter (
		.i_ctrl         (state.ctrl),
		.i_udp_check_en (state.udp_check_en),
		.i_frame        (i_frame),
		.i_station_addr (i_station_addr),
		.o_drop         (filt_drop)
	);

	// Next-state logic for the registers, the status store and the events.
	always_comb begin
		next_state = state;
		next_state.rdata  = '0;
		next_state.accept = 1'b0;
		next_state.drop   = 1'b0;

		// A frame is pending only once fully received and pushed.
		pending  = state.count != '0;
		head     = state.hdr_mem[state.rd_ptr];
		overflow = i_frame.done & ~filt_drop & (state.count == rcf_pkg::CNT_FULL);
		push     = i_frame.done & ~filt_drop & ~overflow;
		// One read of the header status consumes one counted frame.
		pop      = i_rd & pending & rcf_pkg::rcf_hit(i_addr, rcf_pkg::OFF_HDR_STATUS);

		// Free space is sampled every cycle so a read sees a fresh count.
		next_state.tx_free = i_tx_free_bytes;

		// UDP-Lite insertion follows the enable; off means no checksum.
		next_state.tx_gen = i_tx_is_udp_lite & state.ctrl.udplite_en;

		// Software writes; read-only and reserved addresses ignore writes.
		if (i_wr) begin
			if (rcf_pkg::rcf_hit(i_addr, rcf_pkg::OFF_CTRL_TWO)) begin
				next_state.ctrl = rcf_pkg::rcf_ctrl_t'(i_wdata[rcf_pkg::CTRL_W-1:0]);
			end
			if (rcf_pkg::rcf_hit(i_addr, rcf_pkg::OFF_UDP_CHECK)) begin
				next_state.udp_check_en = i_wdata[0];
			end
			if (rcf_pkg::rcf_hit(i_addr, rcf_pkg::OFF_IRQ_MASK)) begin
				next_state.irq_mask = i_wdata[rcf_pkg::IRQ_W-1:0];
			end
		end

		// Read data for the cycle after the strobe; unmapped reads give zero.
		if (i_rd) begin
			unique case (1'b1)
				rcf_pkg::rcf_hit(i_addr, rcf_pkg::OFF_CTRL_TWO): begin
					// Bits 15..5 are reserved and read zero.
					next_state.rdata[rcf_pkg::CTRL_W-1:0] = state.ctrl;
				end
				rcf_pkg::rcf_hit(i_addr, rcf_pkg::OFF_TX_FREE): begin
					next_state.rdata[rcf_pkg::TX_FREE_W-1:0] = state.tx_free;
				end
				rcf_pkg::rcf_hit(i_addr, rcf_pkg::OFF_RESERVED): begin
					// No function here; reads zero and writes vanish.
					next_state.rdata = '0;
				end
				rcf_pkg::rcf_hit(i_addr, rcf_pkg::OFF_HDR_STATUS): begin
					// Nothing pending shows as an all-zero word.
					next_state.rdata[rcf_pkg::BIT_FRAME_VALID] = pending;
					next_state.rdata[rcf_pkg::BIT_ICMP_ERR]    = pending & head.icmp_err;
					next_state.rdata[rcf_pkg::BIT_IP_ERR]      = pending & head.ip_err;
				end
				rcf_pkg::rcf_hit(i_addr, rcf_pkg::OFF_IRQ_STATUS): begin
					next_state.rdata[rcf_pkg::IRQ_W-1:0] = state.irq_status;
				end
				rcf_pkg::rcf_hit(i_addr, rcf_pkg::OFF_IRQ_MASK): begin
					next_state.rdata[rcf_pkg::IRQ_W-1:0] = state.irq_mask;
				end
				rcf_pkg::rcf_hit(i_addr, rcf_pkg::OFF_UDP_CHECK): begin
					next_state.rdata[0] = state.udp_check_en;
				end
				rcf_pkg::rcf_hit(i_addr, rcf_pkg::OFF_FRAME_CNT): begin
					next_state.rdata[rcf_pkg::CNT_W-1:0] = state.count;
				end
				default: begin
					next_state.rdata = '0;
				end
			endcase
		end

		// Store the flags of an accepted frame behind the older ones.
		if (push) begin
			next_state.hdr_mem[state.wr_ptr].icmp_err = i_frame.icmp_csum_bad;
			next_state.hdr_mem[state.wr_ptr].ip_err   = i_frame.ip_csum_bad;
			next_state.wr_ptr = state.wr_ptr + 1'b1;
		end
		if (pop) begin
			next_state.rd_ptr = state.rd_ptr + 1'b1;
		end
		// Push and pop together leave the count alone.
		if (push && !pop) begin
			next_state.count = state.count + 1'b1;
		end else if (pop && !push) begin
			next_state.count = state.count - 1'b1;
		end

		// Frame outcome pulses, one cycle after the decision.
		next_state.accept = push;
		next_state.drop   = i_frame.done & (filt_drop | overflow);

		// Sticky events; a read clears them but a new event in that cycle wins.
		events = '0;
		events[rcf_pkg::IRQ_ACCEPT]   = push;
		events[rcf_pkg::IRQ_DROP]     = i_frame.done & filt_drop;
		events[rcf_pkg::IRQ_OVERFLOW] = overflow;
		if (i_rd && rcf_pkg::rcf_hit(i_addr, rcf_pkg::OFF_IRQ_STATUS)) begin
			next_state.irq_status = events;
		end else begin
			next_state.irq_status = state.irq_status | events;
		end
	end

	// Single register for the whole state; synchronous reset.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state              <= '0;
			state.ctrl         <= rcf_pkg::rcf_ctrl_t'(rcf_pkg::CTRL_RESET);
		end else begin
			state <= next_state;
		end
	end

	// Outputs straight from the registered state.
	assign o_rdata               = state.rdata;
	assign o_rx_accept           = state.accept;
	assign o_rx_drop             = state.drop;
	assign o_frame_count         = state.count;
	assign o_tx_udplite_csum_gen = state.tx_gen;
	assign o_ctrl                = state.ctrl;
	assign o_udp_check_en        = state.udp_check_en;
	// Level interrupt, high while any unmasked sticky bit stands.
	assign o_irq                 = |(state.irq_status & state.irq_mask);

	// The host must check free space itself; nothing here blocks writes.

endmodule

// File: pkg/rcf_pkg.sv
// Purpose: Shared constants and carrier types for the receive checksum filter register bank.
// Assumes: 8-bit byte address, 16-bit register data, one clock.
// Notes:   Every offset, field position and reset value lives here by name.

package rcf_pkg;

	// Register bus widths.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] OFF_CTRL_TWO   = 8'h76;
	localparam logic [ADDR_W-1:0] OFF_TX_FREE    = 8'h78;
	localparam logic [ADDR_W-1:0] OFF_RESERVED   = 8'h7a;
	localparam logic [ADDR_W-1:0] OFF_HDR_STATUS = 8'h7c;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h60;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK   = 8'h62;
	localparam logic [ADDR_W-1:0] OFF_UDP_CHECK  = 8'h64;
	localparam logic [ADDR_W-1:0] OFF_FRAME_CNT  = 8'h66;

	// Control register two layout and reset value (bits 4..0).
	localparam int             CTRL_W     = 5;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h04;

	// Free space field width (bits 12..0).
	localparam int TX_FREE_W = 13;

	// Header status field positions.
	localparam int BIT_FRAME_VALID = 15;
	localparam int BIT_ICMP_ERR    = 13;
	localparam int BIT_IP_ERR      = 12;

	// Interrupt status and mask layout.
	localparam int IRQ_W        = 3;
	localparam int IRQ_ACCEPT   = 0;
	localparam int IRQ_DROP     = 1;
	localparam int IRQ_OVERFLOW = 2;

	// Pending header status store.
	localparam int             HDR_DEPTH = 4;
	localparam int             PTR_W     = 2;
	localparam int             CNT_W     = 3;
	localparam logic [CNT_W-1:0] CNT_FULL  = 3'h4;

	// Software controls of control register two, MSB is bit 4.
	typedef struct packed {
		logic frag_pass;      // Fragmented UDP frames pass the checksum check.
		logic zero_accept;    // UDP frames with zero checksum are accepted.
		logic udplite_en;     // UDP-Lite checksum check and generation.
		logic icmp_en;        // ICMP checksum check of unfragmented frames.
		logic sa_drop;        // Drop frames sourced from our own address.
	} rcf_ctrl_t;

	// Classification of one received frame, valid while done is high.
	typedef struct packed {
		logic        done;
		logic        is_udp;
		logic        is_udp_lite;
		logic        is_icmp;
		logic        is_fragment;
		logic        udp_csum_zero;
		logic        udp_csum_bad;
		logic        udplite_csum_bad;
		logic        icmp_csum_bad;
		logic        ip_csum_bad;
		logic [47:0] src_addr;
	} rcf_frame_t;

	// Stored per-frame header status flags.
	typedef struct packed {
		logic icmp_err;
		logic ip_err;
	} rcf_hdr_t;

	// Address compare, used by every decode.
	function automatic logic rcf_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
		return addr == off;
	endfunction

endpackage

// File: test/rcf_host.sv
// Purpose: Host processor model on the strobe register bus.
// Assumes: Slave answers reads in the next cycle without wait.
// Notes:   Leaves one idle cycle between strobes to keep drivers simple.
`timescale 1ns/1ps
module rcf_host (
	// Clock.
	input  wire logic                     i_clk,
	// Bus master side.
	output logic [rcf_pkg::ADDR_W-1:0]    o_addr,
	output logic [rcf_pkg::DATA_W-1:0]    o_wdata,
	output logic                          o_wr,
	output logic                          o_rd
);
	// Idle bus at time zero.
	initial begin
		o_addr = 8'h00;
		o_wdata = 16'h0000;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// One write cycle; data scrambled afterwards so stale values never look valid.
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_wdata <= ~d;
	endtask
	// One read cycle; address inverted afterwards so stale values never look valid.
	task automatic rd_reg(input logic [7:0] a);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
	endtask
endmodule

// File: test/rcf_regs_monitor.sv
// Purpose: Port-level checks of the receive checksum filter register bank.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to every rcf_regs instance.
`timescale 1ns/1ps
module rcf_regs_monitor (
	// Clock, reset and bus.
	input wire logic                         i_clk,
	input wire logic                         i_reset,
	input wire logic [rcf_pkg::ADDR_W-1:0]   i_addr,
	input wire logic [rcf_pkg::DATA_W-1:0]   i_wdata,
	input wire logic                         i_wr,
	input wire logic                         i_rd,
	input wire logic [rcf_pkg::DATA_W-1:0]   o_rdata,
	// Receive, transmit and control.
	input wire rcf_pkg::rcf_frame_t          i_frame,
	input wire logic [47:0]                  i_station_addr,
	input wire logic                         o_rx_accept,
	input wire logic                         o_rx_drop,
	input wire logic [rcf_pkg::CNT_W-1:0]    o_frame_count,
	input wire logic [rcf_pkg::TX_FREE_W-1:0] i_tx_free_bytes,
	input wire logic                         i_tx_is_udp_lite,
	input wire logic                         o_tx_udplite_csum_gen,
	input wire rcf_pkg::rcf_ctrl_t           o_ctrl
);
	// All checks share one clock domain.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// A read strobe at one offset.
	sequence rd_of(logic [7:0] a);
		i_rd && i_addr == a;
	endsequence
	// A frame from our own station address while filtering is on.
	sequence own_src;
		i_frame.done && o_ctrl.sa_drop && i_frame.src_addr == i_station_addr;
	endsequence
	chk_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000) else $error("read data not zero");
	chk_ctrl_write: assert property (i_wr && i_addr == rcf_pkg::OFF_CTRL_TWO |=> o_ctrl == $past(i_wdata[4:0]))
		else $error("control write lost");
	chk_ctrl_read: assert property (rd_of(rcf_pkg::OFF_CTRL_TWO) |=> o_rdata == {11'h000, $past(o_ctrl)})
		else $error("control read wrong");
	chk_free_read: assert property (rd_of(rcf_pkg::OFF_TX_FREE) ##0 $stable(i_tx_free_bytes)
		|=> o_rdata == {3'h0, $past(i_tx_free_bytes)}) else $error("free space wrong");
	chk_resv_read: assert property (rd_of(rcf_pkg::OFF_RESERVED) |=> o_rdata == 16'h0000) else $error("gap");
	chk_valid_bit: assert property (rd_of(rcf_pkg::OFF_HDR_STATUS)
		|=> o_rdata[15] == ($past(o_frame_count) != 3'h0)) else $error("valid bit wrong");
	chk_frame_answer: assert property (i_frame.done |=> o_rx_accept != o_rx_drop) else $error("no answer");
	chk_no_pulse: assert property (!i_frame.done |=> !o_rx_accept && !o_rx_drop) else $error("stray pulse");
	chk_sa_drop: assert property (own_src |=> o_rx_drop) else $error("own frame kept");
	chk_icmp_drop: assert property (i_frame.done && o_ctrl.icmp_en && i_frame.is_icmp
		&& !i_frame.is_fragment && i_frame.icmp_csum_bad |=> o_rx_drop) else $error("bad icmp kept");
	chk_zero_drop: assert property (i_frame.done && i_frame.is_udp && i_frame.udp_csum_zero
		&& !o_ctrl.zero_accept |=> o_rx_drop) else $error("zero sum kept");
	// The edge that releases reset still sees reset high, so no attempt starts there.
	chk_lite_gen: assert property (!i_reset |=> o_tx_udplite_csum_gen
		== ($past(i_tx_is_udp_lite) && $past(o_ctrl.udplite_en))) else $error("lite generation wrong");
	chk_count_max: assert property (o_frame_count <= rcf_pkg::CNT_FULL) else $error("count too big");
endmodule
bind rcf_regs rcf_regs_monitor i_mon (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_frame,
	.i_station_addr, .o_rx_accept, .o_rx_drop, .o_frame_count, .i_tx_free_bytes, .i_tx_is_udp_lite,
	.o_tx_udplite_csum_gen, .o_ctrl);

// File: test/testbench.sv
// Purpose: Self-checking bench of the register bank.
// Assumes: 25 MHz clock.
// Notes:   Expected results queue up; a negedge watcher compares them.
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0, rst = 1'b1, rd_prev = 1'b0, lite = 1'b0;
	logic [7:0] addr;
	logic [15:0] wdata, rdata, v;
	logic wr, rd, acc, drp, irq, gen, uce;
	logic [2:0] cnt;
	logic [12:0] tx_free = 13'h0000;
	logic [47:0] stn = 48'h0;
	rcf_pkg::rcf_frame_t frame = '0;
	rcf_pkg::rcf_ctrl_t ctrl;
	logic [15:0] rd_q[$];
	logic fr_q[$];
	int error_cnt = 0, n_compared = 0;
	// Filter cases: {control, flags, own source, drop}.
	logic [15:0] cases[11] = '{16'h84a0, 16'h04a1, 16'h4440, 16'h0441, 16'h2211, 16'h0210,
		16'h1109, 16'h1188, 16'h0108, 16'h0803, 16'h0002};
	always #20 clk = ~clk;
	rcf_host i_host (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
	rcf_regs i_dut (.i_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_frame(frame), .i_station_addr(stn), .o_rx_accept(acc), .o_rx_drop(drp),
		.o_frame_count(cnt), .i_tx_free_bytes(tx_free), .i_tx_is_udp_lite(lite),
		.o_tx_udplite_csum_gen(gen), .o_ctrl(ctrl), .o_udp_check_en(uce), .o_irq(irq));
	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		rd_q.push_back(e);
		i_host.rd_reg(a);
	endtask
	// One classified frame; the answer is queued for the watcher.
	task automatic send(input logic [15:0] e, input logic ipb);
		@(posedge clk);
		frame <= {1'b1, e[10:3], ipb, e[1] ? stn : ~stn};
		fr_q.push_back(e[0]);
		@(posedge clk);
		frame <= {1'b0, 9'h1aa, ~stn};
	endtask
	// Transmit type toggles randomly so generation gating is exercised.
	always @(posedge clk) begin
		rd_prev <= rd;
		lite <= 1'($urandom);
	end
	// Compare settled outputs against the oldest note.
	always @(negedge clk) begin
		if (rd_prev === 1'b1) cmp("read data", rd_q.pop_front(), rdata);
		if ((acc | drp) === 1'b1) cmp("drop", {15'h0, fr_q.pop_front()}, {15'h0, drp});
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		final_report();
	end
	initial begin
		v = 16'($urandom(32'hee9fa298));
		stn <= {16'($urandom), 32'($urandom)};
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd_chk(rcf_pkg::OFF_CTRL_TWO, 16'h0004);
		rd_chk(rcf_pkg::OFF_HDR_STATUS, 16'h0000);
		i_host.wr_reg(rcf_pkg::OFF_RESERVED, 16'hffff);
		rd_chk(rcf_pkg::OFF_RESERVED, 16'h0000);
		rd_chk(8'h10, 16'h0000);
		v = 16'($urandom);
		tx_free <= v[12:0];
		rd_chk(rcf_pkg::OFF_TX_FREE, {3'h0, v[12:0]});
		// With the UDP check still off a bad UDP checksum must not drop the frame.
		send(16'h04a0, 1'b0);
		rd_chk(rcf_pkg::OFF_HDR_STATUS, 16'h8000);
		i_host.wr_reg(rcf_pkg::OFF_UDP_CHECK, 16'h0001);
		rd_chk(rcf_pkg::OFF_UDP_CHECK, 16'h0001);
		cmp("check enable", 16'h0001, {15'h0, uce});
		// Fragment, zero sum, lite, icmp and own source cases, each accepted one followed by its header.
		foreach (cases[k]) begin
			i_host.wr_reg(rcf_pkg::OFF_CTRL_TWO, {11'h0, cases[k][15:11]});
			v[0] = 1'($urandom);
			send(cases[k], v[0]);
			if (!cases[k][0]) rd_chk(rcf_pkg::OFF_HDR_STATUS, {2'h2, cases[k][3], v[0], 12'h0});
		end
		rd_chk(rcf_pkg::OFF_IRQ_STATUS, 16'h0003);
		// Look at the level output away from the edge that may change it.
		@(negedge clk);
		cmp("irq", 16'h0000, {15'h0, irq});
		i_host.wr_reg(rcf_pkg::OFF_IRQ_MASK, 16'h0004);
		rd_chk(rcf_pkg::OFF_IRQ_MASK, 16'h0004);
		for (int i = 0; i < 5; i++) send(16'h0000 | 16'(i == 4), 1'b0);
		repeat (2) @(negedge clk);
		cmp("count", 16'h0004, {13'h0, cnt});
		cmp("irq", 16'h0001, {15'h0, irq});
		rd_chk(rcf_pkg::OFF_FRAME_CNT, 16'h0004);
		for (int i = 0; i < 5; i++) rd_chk(rcf_pkg::OFF_HDR_STATUS, (i < 4) ? 16'h8000 : 16'h0000);
		repeat (2) @(posedge clk);
		final_report();
	end
endmodule
